// >>> inc/spot_pkg.sv
// constants shared by the start-up sequencer and the pixel port ends
package spot_pkg;
   // clock rate
   localparam int unsigned CLK_MHZ          = 50;
   // times in their printed units
   localparam int unsigned T_STRAP_SETUP_US = 0;
   localparam int unsigned T_STRAP_HOLD_US  = 50;
   localparam int unsigned T_RESET_CYC      = 10;
   localparam int unsigned T_INIT_MS        = 50;
   localparam int unsigned T_PATCH_MS       = 400;
   localparam int unsigned T_FLASH_MS       = 18;
   localparam real         T_SDL_MS         = 1.8;
   localparam int unsigned T_FV_MS          = 235;
   localparam int unsigned T_OVL_MS         = 235;
   localparam int unsigned T_AE_MS          = 400;
   localparam int unsigned T_OFF_MS         = 100;
   // derived cycle counts, fractional times rounded to nearest
   localparam int unsigned STRAP_HOLD_CYC   = T_STRAP_HOLD_US * CLK_MHZ;
   localparam int unsigned STRAP_SMPL_CYC   = STRAP_HOLD_CYC / 2;
   localparam int unsigned INIT_CYC         = T_INIT_MS * 1000 * CLK_MHZ;
   localparam int unsigned PATCH_CYC        = T_PATCH_MS * 1000 * CLK_MHZ;
   localparam int unsigned FLASH_CYC        = T_FLASH_MS * 1000 * CLK_MHZ;
   localparam int unsigned SDL_CYC          = int'(T_SDL_MS * 1000.0 * CLK_MHZ);
   localparam int unsigned FV_CYC           = T_FV_MS * 1000 * CLK_MHZ;
   localparam int unsigned OVL_CYC          = T_OVL_MS * 1000 * CLK_MHZ;
   localparam int unsigned AE_CYC           = T_AE_MS * 1000 * CLK_MHZ;
   localparam int unsigned OFF_CYC          = T_OFF_MS * 1000 * CLK_MHZ;
   // pixel clock half period in clk_in cycles
   localparam int unsigned PCLK_HALF        = 4;
   // register map
   localparam logic [15:0] CLK_POL_ADDR     = 16'h0016;
   localparam logic [15:0] PAD_SLEW_ADDR    = 16'h0030;
   localparam int unsigned CLK_INV_BIT      = 14;
   localparam int unsigned PCLK_SLEW_LSB    = 8;
   localparam int unsigned DATA_SLEW_LSB    = 0;
   localparam int unsigned SLEW_W           = 3;
   localparam logic [15:0] CLK_POL_RESET    = 16'h0000;
   localparam logic [15:0] PAD_SLEW_RESET   = 16'h0000;
   // strap pin positions
   localparam int unsigned STRAP_CFG        = 0;
   localparam int unsigned STRAP_FV         = 1;
   localparam int unsigned STRAP_LV         = 2;
endpackage

// >>> inc/spot_if.sv
// pins between the camera device end and the capture/reset end
`timescale 1ns/1ns
interface spot_if;
   logic       hard_reset_n;     // active-low hard reset, from host
   logic       pixel_clock;      // pixel clock, from device
   logic [7:0] pixel_data;       // pixel data bus, from device
   logic [2:0] pin_dev_o;        // device drive of lv, fv, strap bit
   logic [2:0] pin_dev_oe;       // device enables
   logic [2:0] pin_host_o;       // host strap levels
   logic [2:0] pin_host_oe;      // host strap enables
   logic       flash_select_n;   // flash chip select, from device
   logic       sdl_dev_oe;       // device pulls serial_data_line low
   logic       config_strap_bit; // resolved pin levels
   logic       frame_valid;
   logic       line_valid;
   logic       serial_data_line;
   logic [2:0] pin_lvl;

   // device wins, then host, else weak pull-down
   assign pin_lvl = (pin_dev_oe & pin_dev_o) |
                    (~pin_dev_oe & pin_host_oe & pin_host_o);
   assign config_strap_bit = pin_lvl[0];
   assign frame_valid      = pin_lvl[1];
   assign line_valid       = pin_lvl[2];
   // open drain with pull-up
   assign serial_data_line = ~sdl_dev_oe;

   modport dev (input hard_reset_n, config_strap_bit, frame_valid,
                input line_valid,
                output pixel_clock, pixel_data, pin_dev_o, pin_dev_oe,
                output flash_select_n, sdl_dev_oe);
   modport host (output hard_reset_n, pin_host_o, pin_host_oe,
                 input pixel_clock, pixel_data, frame_valid, line_valid,
                 input config_strap_bit, flash_select_n,
                 input serial_data_line);
endinterface

// >>> hdl/spot_host.sv
// capture logic and reset controller end of the pixel link
`timescale 1ns/1ns
module spot_host #(
   parameter int unsigned OFF_CYC   = spot_pkg::OFF_CYC,
   parameter int unsigned RESET_CYC = spot_pkg::T_RESET_CYC,
   parameter int unsigned HOLD_CYC  = spot_pkg::STRAP_HOLD_CYC
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       power_cycle_in,  // start a power cycle
   input  wire logic [2:0] strap_in,        // strap levels to present
   input  wire logic       pol_inv_in,      // pixel clock is inverted
   output logic [7:0]      cap_data_out,
   output logic            cap_fv_out,
   output logic            cap_lv_out,
   output logic            cap_strobe_out,
   spot_if.host            link
);
   initial begin
      if (RESET_CYC < spot_pkg::T_RESET_CYC || HOLD_CYC < 1)
         $error("spot_host: reset or hold count too short");
   end

   typedef enum logic [3:0] {
      H_OFF   = 4'b0001,  // supply down, wait for discharge
      H_HOLD  = 4'b0010,  // reset held low
      H_STRAP = 4'b0100,  // reset released, straps still driven
      H_RUN   = 4'b1000   // straps released
   } spot_hst_t;

   spot_hst_t   st_q, st_d;     // controller state
   logic [31:0] cnt_q, cnt_d;   // cycles in H_OFF, H_HOLD or H_STRAP, frozen in H_RUN
   logic        rstn_q, rstn_d; // hard reset pin drive
   logic [2:0]  soe_q, soe_d;   // strap enables
   logic [10:0] s1_q, s2_q;     // synchronisers: clk, lv, fv, data
   logic        pc_q;           // previous synced pixel clock
   logic        edge_w;         // sampling edge seen
   logic [7:0]  dat_q, dat_d;
   logic        fv_q, fv_d, lv_q, lv_d, stb_q, stb_d;

   // sampling edge is rising by default, falling when inverted
   assign edge_w = pol_inv_in ? (pc_q & ~s2_q[10]) : (~pc_q & s2_q[10]);

   // reset and strap sequencing
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q + 32'h1;
      rstn_d = 1'b0;
      soe_d  = 3'b111;
      case (st_q)
         H_OFF: begin
            if (cnt_q >= OFF_CYC - 1) begin
               st_d  = H_HOLD;
               cnt_d = 32'h0;
            end
         end
         H_HOLD: begin
            if (cnt_q >= RESET_CYC - 1) begin
               st_d   = H_STRAP;
               cnt_d  = 32'h0;
               rstn_d = 1'b1;
            end
         end
         H_STRAP: begin
            rstn_d = 1'b1;
            if (cnt_q >= HOLD_CYC) begin
               st_d  = H_RUN;
               soe_d = 3'b000;
            end
         end
         default: begin
            rstn_d = 1'b1;
            soe_d  = 3'b000;
            cnt_d  = cnt_q;
         end
      endcase
      if (power_cycle_in) begin
         st_d   = H_OFF;
         cnt_d  = 32'h0;
         rstn_d = 1'b0;
         soe_d  = 3'b111;
      end
   end

   // capture on the sampling edge of the synced pixel clock
   always_comb begin
      dat_d = dat_q;
      fv_d  = fv_q;
      lv_d  = lv_q;
      stb_d = edge_w;
      if (edge_w) begin
         dat_d = s2_q[7:0];
         fv_d  = s2_q[8];
         lv_d  = s2_q[9];
      end
   end

   // register everything; pins pass two flops first
   always_ff @(posedge clk_in) begin
      s1_q <= {link.pixel_clock, link.line_valid, link.frame_valid,
               link.pixel_data};
      s2_q <= s1_q;
      if (rst_in) begin
         st_q  <= H_HOLD;
         cnt_q <= 32'h0;
         rstn_q <= 1'b0;
         soe_q <= 3'b111;
         pc_q  <= 1'b0;
         dat_q <= 8'h00;
         fv_q  <= 1'b0;
         lv_q  <= 1'b0;
         stb_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         rstn_q <= rstn_d;
         soe_q <= soe_d;
         pc_q  <= s2_q[10];
         dat_q <= dat_d;
         fv_q  <= fv_d;
         lv_q  <= lv_d;
         stb_q <= stb_d;
      end
   end

   assign link.hard_reset_n = rstn_q;
   assign link.pin_host_oe  = soe_q;
   assign link.pin_host_o   = strap_in;
   assign cap_data_out      = dat_q;
   assign cap_fv_out        = fv_q;
   assign cap_lv_out        = lv_q;
   assign cap_strobe_out    = stb_q;
endmodule

// >>> hdl/spot_dev.sv
// camera device end: start-up sequencer, registers and pixel launch
// Operation
// - launch pixel outputs on pixel clock falling edge
// - receiver samples on pixel clock rising edge
// - clock control bit 14 inverts pixel clock
// - pad control holds two 3-bit drive speeds
// - sample three straps once during start-up
// - straps stable until 50 us after release
// - reset held ten clocks after supplies settle
// - load patches over flash or host port
// - flash select low no sooner than 18 ms
// - serial data low no sooner than 1.8 ms
// - frame valid no sooner than 235 ms
// - first overlay no sooner than 235 ms
// - exposure and balance settle about 400 ms
// - wait 100 ms between power down and up
// - hard reset low restores register defaults
`timescale 1ns/1ns
module spot_dev #(
   parameter int unsigned SMPL_CYC  = spot_pkg::STRAP_SMPL_CYC,
   parameter int unsigned INIT_CYC  = spot_pkg::INIT_CYC,
   parameter int unsigned PATCH_CYC = spot_pkg::PATCH_CYC,
   parameter int unsigned FLASH_CYC = spot_pkg::FLASH_CYC,
   parameter int unsigned SDL_CYC   = spot_pkg::SDL_CYC,
   parameter int unsigned FV_CYC    = spot_pkg::FV_CYC,
   parameter int unsigned OVL_CYC   = spot_pkg::OVL_CYC,
   parameter int unsigned AE_CYC    = spot_pkg::AE_CYC,
   parameter int unsigned HALF_CYC  = spot_pkg::PCLK_HALF
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        reg_wr_in,     // register write strobe
   input  wire logic [15:0] reg_addr_in,   // register address
   input  wire logic [15:0] reg_wdata_in,  // register write data
   input  wire logic [7:0]  pix_data_in,   // pixel stream to launch
   input  wire logic        pix_fv_in,
   input  wire logic        pix_lv_in,
   input  wire logic        sdl_pull_in,   // request to pull data line
   output logic [15:0]      reg_rdata_out, // read data, one cycle late
   output logic [2:0]       strap_out,     // straps as sampled
   output logic             patching_out,  // flash select low, flash patch load only
   output logic             running_out,   // start-up complete
   output logic             overlay_on_out,
   output logic             ae_settled_out,
   output logic [2:0]       pclk_slew_out, // pixel clock drive speed
   output logic [2:0]       data_slew_out, // data drive speed
   spot_if.dev              link
);
   initial begin
      if (SMPL_CYC >= spot_pkg::STRAP_HOLD_CYC || HALF_CYC < 1 ||
          INIT_CYC < SMPL_CYC)
         $error("spot_dev: strap sample or divider out of range");
   end

   typedef enum logic [4:0] {
      S_RESET = 5'b00001,  // hard reset held
      S_STRAP = 5'b00010,  // waiting to sample straps
      S_INIT  = 5'b00100,  // internal initialisation
      S_PATCH = 5'b01000,  // patch load
      S_RUN   = 5'b10000   // streaming
   } spot_st_t;

   localparam int unsigned PW = $clog2(HALF_CYC + 1);

   // synchronisers for hard reset and strap pins
   logic        hr1_q, hr2_q;
   logic [2:0]  sp1_q, sp2_q;
   // sequencer
   spot_st_t    st_q, st_d;
   logic [31:0] el_q, el_d;         // cycles since reset release
   logic [2:0]  strap_q, strap_d;   // sampled straps
   logic        sdl_en_q, sdl_en_d; // data line may be pulled
   logic        fsel_q, fsel_d;     // flash select, active low
   logic        sdl_q, sdl_d;       // data line pull
   logic        ovl_q, ovl_d;
   logic        ae_q, ae_d;
   // registers
   logic [15:0] pol_q, pol_d;
   logic [15:0] slew_q, slew_d;
   logic [15:0] rd_q, rd_d;
   // pixel clock divider and launch
   logic [PW-1:0] div_q, div_d;
   logic        pck_q, pck_d;       // internal pixel clock
   logic        pin_q, pin_d;       // pixel clock at the pin
   logic [7:0]  dat_q, dat_d;
   logic        fv_q, fv_d, lv_q, lv_d, oe_q, oe_d;
   logic        launch_w;           // internal clock falls now
   logic        pix_en_w;           // frame outputs allowed

   assign launch_w = pck_q && (div_q == PW'(HALF_CYC - 1));
   assign pix_en_w = (st_q == S_RUN) && (el_q >= FV_CYC);

   // start-up sequence timed from hard reset release
   always_comb begin
      st_d     = st_q;
      el_d     = (el_q == 32'hffff_ffff) ? el_q : el_q + 32'h1;
      strap_d  = strap_q;
      sdl_en_d = sdl_en_q;
      fsel_d   = 1'b1;
      ovl_d    = ovl_q;
      ae_d     = ae_q;
      case (st_q)
         S_RESET: begin
            el_d = 32'h0;
            st_d = S_STRAP;
         end
         S_STRAP: begin
            // one sample only, inside the hold window
            if (el_q == SMPL_CYC) begin
               strap_d = sp2_q;
               st_d    = S_INIT;
            end
         end
         S_INIT: begin
            if (el_q >= INIT_CYC)
               st_d = S_PATCH;
         end
         S_PATCH: begin
            // flash mode selects flash only after its delay
            fsel_d = ~(strap_q[spot_pkg::STRAP_CFG] &&
                       el_q >= FLASH_CYC);
            if (el_q >= INIT_CYC + PATCH_CYC)
               st_d = S_RUN;
         end
         default: begin
            ovl_d = ovl_q | (el_q >= OVL_CYC);
            ae_d  = ae_q | (el_q >= AE_CYC);
         end
      endcase
      if (st_q != S_RESET)
         sdl_en_d = sdl_en_q | (el_q >= SDL_CYC);
      if (!hr2_q) begin
         // hard reset: everything back to passive
         st_d     = S_RESET;
         el_d     = 32'h0;
         sdl_en_d = 1'b0;
         fsel_d   = 1'b1;
         ovl_d    = 1'b0;
         ae_d     = 1'b0;
      end
      sdl_d = sdl_en_d & sdl_pull_in;
   end

   // register writes and reads
   always_comb begin
      pol_d  = pol_q;
      slew_d = slew_q;
      rd_d   = 16'h0000;
      if (reg_addr_in == spot_pkg::CLK_POL_ADDR) begin
         rd_d = pol_q;
         if (reg_wr_in)
            pol_d = reg_wdata_in;
      end else if (reg_addr_in == spot_pkg::PAD_SLEW_ADDR) begin
         rd_d = slew_q;
         if (reg_wr_in)
            slew_d = reg_wdata_in;
      end
      if (!hr2_q) begin
         pol_d  = spot_pkg::CLK_POL_RESET;
         slew_d = spot_pkg::PAD_SLEW_RESET;
      end
   end

   // divider and launch of data, frame and line valid
   always_comb begin
      div_d = launch_w || div_q == PW'(HALF_CYC - 1) ? '0 : div_q + 1'b1;
      pck_d = (div_q == PW'(HALF_CYC - 1)) ? ~pck_q : pck_q;
      // inverted polarity moves the launch to the pin's rising edge
      pin_d = pck_d ^ pol_q[spot_pkg::CLK_INV_BIT];
      dat_d = dat_q;
      fv_d  = fv_q;
      lv_d  = lv_q;
      oe_d  = oe_q;
      if (launch_w) begin
         // all outputs change on the internal falling edge
         oe_d  = pix_en_w;
         dat_d = pix_en_w ? pix_data_in : 8'h00;
         fv_d  = pix_en_w & pix_fv_in;
         lv_d  = pix_en_w & pix_lv_in;
      end
      if (!pix_en_w) begin
         // straps share these pins: stay off until streaming
         oe_d  = 1'b0;
         dat_d = 8'h00;
         fv_d  = 1'b0;
         lv_d  = 1'b0;
      end
   end

   // registers; pins pass two flops first
   always_ff @(posedge clk_in) begin
      hr1_q <= link.hard_reset_n;
      hr2_q <= hr1_q;
      sp1_q <= {link.line_valid, link.frame_valid, link.config_strap_bit};
      sp2_q <= sp1_q;
      if (rst_in) begin
         st_q     <= S_RESET;
         el_q     <= 32'h0;
         strap_q  <= 3'b000;
         sdl_en_q <= 1'b0;
         fsel_q   <= 1'b1;
         sdl_q    <= 1'b0;
         ovl_q    <= 1'b0;
         ae_q     <= 1'b0;
         pol_q    <= spot_pkg::CLK_POL_RESET;
         slew_q   <= spot_pkg::PAD_SLEW_RESET;
         rd_q     <= 16'h0000;
         div_q    <= '0;
         pck_q    <= 1'b0;
         pin_q    <= 1'b0;
         dat_q    <= 8'h00;
         fv_q     <= 1'b0;
         lv_q     <= 1'b0;
         oe_q     <= 1'b0;
      end else begin
         st_q     <= st_d;
         el_q     <= el_d;
         strap_q  <= strap_d;
         sdl_en_q <= sdl_en_d;
         fsel_q   <= fsel_d;
         sdl_q    <= sdl_d;
         ovl_q    <= ovl_d;
         ae_q     <= ae_d;
         pol_q    <= pol_d;
         slew_q   <= slew_d;
         rd_q     <= rd_d;
         div_q    <= div_d;
         pck_q    <= pck_d;
         pin_q    <= pin_d;
         dat_q    <= dat_d;
         fv_q     <= fv_d;
         lv_q     <= lv_d;
         oe_q     <= oe_d;
      end
   end

   // pins
   assign link.pixel_clock    = pin_q;
   assign link.pixel_data     = dat_q;
   assign link.pin_dev_o      = {lv_q, fv_q, dat_q[0]};
   assign link.pin_dev_oe     = {oe_q, oe_q, oe_q};
   assign link.flash_select_n = fsel_q;
   assign link.sdl_dev_oe     = sdl_q;
   // user side
   assign reg_rdata_out  = rd_q;
   assign strap_out      = strap_q;
   assign patching_out   = ~fsel_q;
   assign running_out    = oe_q;
   assign overlay_on_out = ovl_q;
   assign ae_settled_out = ae_q;
   assign pclk_slew_out  = slew_q[spot_pkg::PCLK_SLEW_LSB +: spot_pkg::SLEW_W];
   assign data_slew_out  = slew_q[spot_pkg::DATA_SLEW_LSB +: spot_pkg::SLEW_W];
endmodule

// >>> tb/spot_monitor.sv
// checker on the pins between the device end and the capture end
`timescale 1ns/1ns
module spot_monitor #(
   parameter int unsigned FLASH_CYC = 150,
   parameter int unsigned SDL_CYC   = 30,
   parameter int unsigned FV_CYC    = 350,
   parameter int unsigned HOLD_CYC  = 40,
   parameter int unsigned RESET_CYC = 10
) (
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       hard_reset_n,
   input wire logic       pixel_clock,
   input wire logic [7:0] pixel_data,
   input wire logic [2:0] pin_dev_o,
   input wire logic [2:0] pin_dev_oe,
   input wire logic [2:0] pin_host_o,
   input wire logic [2:0] pin_host_oe,
   input wire logic       flash_select_n,
   input wire logic       serial_data_line
);
   logic [15:0] cnt_q = 16'h0000; // cycles since hard reset went high
   logic [15:0] cnt_d;
   logic [15:0] low_q = 16'h0000; // cycles hard reset has been low
   logic [15:0] low_d;

   // next values of the two elapsed-time counters, both saturating
   always_comb begin
      if (hard_reset_n) begin
         cnt_d = (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h0001;
         low_d = 16'h0000;
      end else begin
         cnt_d = 16'h0000;
         low_d = (low_q == 16'hffff) ? low_q : low_q + 16'h0001;
      end
   end

   // counters only register their next values
   always_ff @(posedge clk_in) begin
      cnt_q <= cnt_d;
      low_q <= low_d;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_flash_not_early: assert property (
      hard_reset_n && !flash_select_n |-> cnt_q >= FLASH_CYC)
      else $error("flash select went low too soon after reset");
   a_sdl_not_early: assert property (
      hard_reset_n && !serial_data_line |-> cnt_q >= SDL_CYC)
      else $error("serial data line pulled low too soon");
   a_frame_not_early: assert property (
      hard_reset_n && pin_dev_oe != 3'h0 |-> cnt_q >= FV_CYC)
      else $error("frame outputs enabled too soon");
   a_passive_in_reset: assert property (
      low_q >= 16'h0004 |-> flash_select_n && serial_data_line &&
      pin_dev_oe == 3'h0 && pixel_data == 8'h00)
      else $error("device pins not passive during hard reset");
   a_launch_with_clock: assert property (
      pin_dev_oe[1] && $past(pin_dev_oe[1]) &&
      $changed({pixel_data, pin_dev_o[2:1]}) |-> $changed(pixel_clock))
      else $error("pixel outputs moved without a pixel clock edge");
   a_strap_setup: assert property (
      $rose(hard_reset_n) |-> pin_host_oe == 3'h7 && $stable(pin_host_o))
      else $error("straps not steady at reset release");
   a_strap_hold: assert property (
      hard_reset_n && cnt_q < HOLD_CYC |->
      pin_host_oe == 3'h7 && $stable(pin_host_o))
      else $error("straps released before hold time ran out");
   a_reset_width: assert property (
      $rose(hard_reset_n) |-> low_q >= RESET_CYC)
      else $error("hard reset pulse too short");
endmodule

// >>> tb/tb_top.sv
// self-checking bench joining the device end and the capture end
`timescale 1ns/1ns
module tb_top;
   localparam int FLASH = 150; // shortened start-up counts
   localparam int SDL   = 30;
   localparam int FV    = 350;
   localparam int OFF   = 50;
   localparam int RSTC  = 10;
   localparam int SMPL  = 20;
   localparam int INIT  = 100;
   localparam int PATCH = 200;
   localparam int OVL   = 350;
   localparam int AE    = 400;
   localparam int HALF  = 4;
   localparam int HOLD  = 40;

   logic        clk_in = 1'b0;
   logic        rst_in;
   logic        reg_wr;      // register port drive
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [15:0] pv;          // expected pad word
   logic [7:0]  pix_data;    // pixel stream into the device
   logic        pix_fv;
   logic        pix_lv;
   logic        sdl_pull;
   logic        power_cycle;
   logic [2:0]  strap;       // {lv, fv, cfg}
   logic        pol_inv;
   logic [2:0]  strap_smp;
   logic        patching, running, overlay_on, ae_settled;
   logic [2:0]  pclk_slew, data_slew;
   logic [7:0]  cap_data;
   logic        cap_fv, cap_lv;
   logic        cap_strobe;  // one pulse per captured pixel
   int          fl = 0;      // cycles with flash select low
   int          n_stb = 0;   // capture strobes seen
   int          lo0, fl0, s0; // snapshots taken by the tests
   int          el = 0;      // cycles since hard reset high
   int          lo = 0;      // low cycles of hard reset
   int          cyc = 0;     // cycles run, for the hang limit
   int          bad_count = 0;
   int          n_compared = 0;

   spot_if link ();

   spot_dev #(.SMPL_CYC(SMPL), .INIT_CYC(INIT), .PATCH_CYC(PATCH),
      .FLASH_CYC(FLASH), .SDL_CYC(SDL), .FV_CYC(FV), .OVL_CYC(OVL),
      .AE_CYC(AE), .HALF_CYC(HALF)) i_spot_dev (
      .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .pix_data_in(pix_data), .pix_fv_in(pix_fv), .pix_lv_in(pix_lv),
      .sdl_pull_in(sdl_pull), .reg_rdata_out(reg_rdata),
      .strap_out(strap_smp), .patching_out(patching),
      .running_out(running), .overlay_on_out(overlay_on),
      .ae_settled_out(ae_settled), .pclk_slew_out(pclk_slew),
      .data_slew_out(data_slew), .link(link.dev));

   spot_host #(.OFF_CYC(OFF), .RESET_CYC(RSTC), .HOLD_CYC(HOLD))
      i_spot_host (
      .clk_in(clk_in), .rst_in(rst_in), .power_cycle_in(power_cycle),
      .strap_in(strap), .pol_inv_in(pol_inv), .cap_data_out(cap_data),
      .cap_fv_out(cap_fv), .cap_lv_out(cap_lv),
      .cap_strobe_out(cap_strobe),
      .link(link.host));

   spot_monitor #(.FLASH_CYC(FLASH), .SDL_CYC(SDL), .FV_CYC(FV),
      .HOLD_CYC(HOLD), .RESET_CYC(RSTC)) i_spot_monitor (
      .clk_in(clk_in), .rst_in(rst_in), .hard_reset_n(link.hard_reset_n),
      .pixel_clock(link.pixel_clock), .pixel_data(link.pixel_data),
      .pin_dev_o(link.pin_dev_o), .pin_dev_oe(link.pin_dev_oe),
      .pin_host_o(link.pin_host_o), .pin_host_oe(link.pin_host_oe),
      .flash_select_n(link.flash_select_n),
      .serial_data_line(link.serial_data_line));

   // free-running clock, 20 ns period
   always #10 clk_in = ~clk_in;

   // elapsed-time bookkeeping and the hang limit
   always @(posedge clk_in) begin
      el <= (link.hard_reset_n === 1'b1) ? el + 1 : 0;
      if (link.hard_reset_n !== 1'b1) begin
         lo <= lo + 1;
      end
      if (link.flash_select_n === 1'b0) begin
         fl <= fl + 1;
      end
      if (cap_strobe === 1'b1) begin
         n_stb <= n_stb + 1;
      end
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict();
      end
   end

   // one comparison, counted, reported on mismatch
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // wait whole cycles, then settle just past the edge
   task tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // register write, one strobe cycle
   task wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
   endtask

   // register read, data one cycle after the address
   task rd(input logic [15:0] a, input logic [15:0] e);
      reg_addr = a;
      tick(1);
      chk(reg_rdata, e);
   endtask

   // counts, verdict and end of run
   task give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst_in = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      pix_data = 8'h3c;
      pix_fv = 1'b1;
      pix_lv = 1'b1;
      sdl_pull = 1'b1;
      power_cycle = 1'b0;
      strap = 3'b101;
      pol_inv = 1'b0;
      tick(3);
      rst_in = 1'b0;
      // start-up in flash patch mode
      do tick(1); while (link.serial_data_line !== 1'b0);
      chk(16'(el >= SDL), 16'h0001);
      sdl_pull = 1'b0;
      do tick(1); while (patching !== 1'b1);
      chk(16'(link.flash_select_n), 16'h0000);
      chk(16'(el >= FLASH), 16'h0001);
      chk(16'(strap_smp), 16'h0005);
      do tick(1); while (running !== 1'b1);
      chk(16'(el >= FV), 16'h0001);
      chk(16'(link.flash_select_n), 16'h0001);
      chk(16'(ae_settled), 16'h0000);
      tick(2);
      chk(16'(overlay_on), 16'h0001);
      tick(60);
      chk(16'(ae_settled), 16'h0001);
      $display("test start-up done");
      // every drive speed code in both fields, plus an unmapped place
      for (int i = 0; i < 8; i++) begin
         pv = {5'h00, 3'(i), 5'h00, 3'(7 - i)};
         wr(spot_pkg::PAD_SLEW_ADDR, pv);
         rd(spot_pkg::PAD_SLEW_ADDR, pv);
         chk(16'(pclk_slew), 16'(i));
         chk(16'(data_slew), 16'(7 - i));
      end
      wr(16'h0031, 16'hffff);
      rd(16'h0031, 16'h0000);
      $display("test registers done");
      // launch edge and capture, default then inverted polarity
      for (int p = 0; p < 2; p++) begin
         wr(spot_pkg::CLK_POL_ADDR, p[0] ? 16'h4000 : 16'h0000);
         rd(spot_pkg::CLK_POL_ADDR, p[0] ? 16'h4000 : 16'h0000);
         pol_inv = p[0];
         pix_fv = p[0];
         pix_lv = ~p[0];
         pix_data = p[0] ? 8'ha5 : 8'h5a;
         do tick(1); while (link.pixel_data !== pix_data);
         chk(16'(link.pixel_clock), 16'(p));
         tick(12);
         chk(16'(cap_data), 16'(pix_data));
         chk(16'({cap_fv, cap_lv}), 16'({p[0], ~p[0]}));
         s0 = n_stb;
         tick(8);
         chk(16'(n_stb - s0), 16'h0001);
      end
      $display("test pixel port done");
      // power cycle into host patch mode
      strap = 3'b010;
      fl0 = fl;
      lo0 = lo;
      power_cycle = 1'b1;
      tick(1);
      power_cycle = 1'b0;
      do tick(1); while (link.hard_reset_n !== 1'b0);
      tick(5);
      chk(16'({link.flash_select_n, link.serial_data_line,
               link.pin_dev_oe}), 16'h0018);
      chk(16'(link.pixel_data), 16'h0000);
      rd(spot_pkg::CLK_POL_ADDR, spot_pkg::CLK_POL_RESET);
      rd(spot_pkg::PAD_SLEW_ADDR, spot_pkg::PAD_SLEW_RESET);
      do tick(1); while (link.hard_reset_n !== 1'b1);
      chk(16'(lo - lo0 >= OFF + RSTC), 16'h0001);
      do tick(1); while (running !== 1'b1);
      chk(16'(fl - fl0), 16'h0000);
      chk(16'(strap_smp), 16'h0002);
      strap = 3'b111;
      tick(20);
      chk(16'(strap_smp), 16'h0002);
      $display("test power cycle done");
      give_verdict();
   end
endmodule
